// ===== logic/esc_top.sv
// External sample clock select: registers, source routing and clock watch.
`timescale 1ns/1ps
module esc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ext_clk,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic run_start,
  input wire logic run_stop,
  output logic running,
  output logic conv_clk_ext_sel,
  output logic term_50_en,
  output logic clk_out_oe,
  output logic range_fast,
  output logic ext_clk_present,
  output logic ext_clk_lost
);

  ////////////////////////////////////////////////////////////////////////////
  // Link side and crossing.

  logic edge_toggle;

  esc_edge_mon u_mon (
    .ext_clk(ext_clk),
    .rst(rst),
    .edge_toggle(edge_toggle)
  );

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;

  // Plain two-stage synchroniser; the third stage only serves edge detect.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (ce) begin
      sync1_q <= edge_toggle;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers and run state.

  esc_pkg::esc_cfg_t cfg_q;
  esc_pkg::esc_cfg_t cfg_d;
  esc_pkg::esc_run_t run_q;
  esc_pkg::esc_run_t run_d;
  esc_pkg::esc_req_t req;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  always_comb begin
    req.wr = reg_wr;
    req.rd = reg_rd;
    req.addr = reg_addr;
    req.wdata = reg_wdata;
  end

  always_comb begin
    cfg_d = cfg_q;
    run_d = run_q;
    // Writes while running are dropped; a write in the same cycle as run_start
    // still lands, and the clock path then changes one cycle after running rises.
    if (req.wr && run_q == esc_pkg::ESC_STOPPED) begin
      case (req.addr)
        esc_pkg::ADDR_SAMPLE_CLOCK_SOURCE: begin
          cfg_d.source = req.wdata;
        end
        esc_pkg::ADDR_EXTERNAL_RANGE_SELECT: begin
          cfg_d.range_sel = req.wdata;
        end
        esc_pkg::ADDR_CLOCK_INPUT_TERMINATION: begin
          cfg_d.term = req.wdata[esc_pkg::ENABLE_BIT];
        end
        esc_pkg::ADDR_CLOCK_OUTPUT_ENABLE: begin
          cfg_d.clkout = req.wdata[esc_pkg::ENABLE_BIT];
        end
        default: begin
          cfg_d = cfg_q;
        end
      endcase
    end
    case (run_q)
      esc_pkg::ESC_STOPPED: begin
        if (run_start && !run_stop) begin
          run_d = esc_pkg::ESC_RUNNING;
        end
      end
      esc_pkg::ESC_RUNNING: begin
        if (run_stop) begin
          run_d = esc_pkg::ESC_STOPPED;
        end
      end
      default: begin
        run_d = esc_pkg::ESC_STOPPED;
      end
    endcase
  end

  always_comb begin
    rvalid_d = req.rd;
    rdata_d = 32'h0000_0000;
    if (req.rd) begin
      case (req.addr)
        esc_pkg::ADDR_SAMPLE_CLOCK_SOURCE: begin
          rdata_d = cfg_q.source;
        end
        esc_pkg::ADDR_EXTERNAL_RANGE_SELECT: begin
          rdata_d = cfg_q.range_sel;
        end
        esc_pkg::ADDR_CLOCK_INPUT_TERMINATION: begin
          rdata_d[esc_pkg::ENABLE_BIT] = cfg_q.term;
        end
        esc_pkg::ADDR_CLOCK_OUTPUT_ENABLE: begin
          rdata_d[esc_pkg::ENABLE_BIT] = cfg_q.clkout;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q.source <= esc_pkg::SOURCE_RESET;
      cfg_q.range_sel <= esc_pkg::RANGE_RESET;
      cfg_q.term <= esc_pkg::TERM_RESET;
      cfg_q.clkout <= esc_pkg::CLKOUT_RESET;
      run_q <= esc_pkg::ESC_STOPPED;
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      cfg_q <= cfg_d;
      run_q <= run_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock watch and pin controls.

  logic ext_mode;
  logic fast_mode;
  logic edge_seen;

  assign ext_mode = (cfg_q.source == esc_pkg::DIRECT_EXTERNAL_CLOCK_MODE);
  assign fast_mode = (cfg_q.range_sel == esc_pkg::FAST_CLOCK_RANGE);
  assign edge_seen = sync2_q ^ sync3_q;

  logic [esc_pkg::GAP_CNT_W-1:0] gap_q;
  logic [esc_pkg::GAP_CNT_W-1:0] gap_d;
  logic present_q;
  logic present_d;
  logic lost_q;
  logic lost_d;
  logic sel_q;
  logic sel_d;
  logic term_q;
  logic term_d;
  logic oe_q;
  logic oe_d;
  logic fast_q;
  logic fast_d;

  always_comb begin
    gap_d = gap_q;
    present_d = present_q;
    // A silent clock clears the presence flag (and in the fast range sets the loss flag); nothing stops the run,
    // so conversion simply resumes on the next edge.
    if (edge_seen) begin
      gap_d = '0;
      present_d = 1'b1;
    end else if (gap_q < esc_pkg::GAP_LIMIT) begin
      gap_d = gap_q + esc_pkg::GAP_CNT_W'(1);
    end else begin
      present_d = 1'b0;
    end
    // Gaps are legal only in the slow range; in the fast range a missing
    // clock is latched for software. A new start clears it.
    lost_d = lost_q;
    if (run_q == esc_pkg::ESC_STOPPED && run_start) begin
      lost_d = 1'b0;
    end
    if (run_q == esc_pkg::ESC_RUNNING && ext_mode && fast_mode &&
        !present_q) begin
      lost_d = 1'b1;
    end
    sel_d = ext_mode;
    term_d = cfg_q.term && ext_mode;
    oe_d = cfg_q.clkout && !ext_mode;
    fast_d = ext_mode && fast_mode;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_q <= '0;
      present_q <= 1'b0;
      lost_q <= 1'b0;
      sel_q <= 1'b0;
      term_q <= 1'b0;
      oe_q <= 1'b0;
      fast_q <= 1'b0;
    end else if (ce) begin
      gap_q <= gap_d;
      present_q <= present_d;
      lost_q <= lost_d;
      sel_q <= sel_d;
      term_q <= term_d;
      oe_q <= oe_d;
      fast_q <= fast_d;
    end
  end

  // The select drives the analog clock mux directly; the external clock
  // itself never passes through this logic, so no jitter cleaning here.
  assign conv_clk_ext_sel = sel_q;
  assign term_50_en = term_q;
  assign clk_out_oe = oe_q;
  assign range_fast = fast_q;
  assign ext_clk_present = present_q;
  assign ext_clk_lost = lost_q;
  assign running = (run_q == esc_pkg::ESC_RUNNING);
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

endmodule

// ===== logic/esc_pkg.sv
// Constants and types for the external sample clock select block.
package esc_pkg;

  // Register offsets, as the driver numbers them.
  localparam logic [15:0] ADDR_CLOCK_OUTPUT_ENABLE = 16'h4E8E;
  localparam logic [15:0] ADDR_CLOCK_INPUT_TERMINATION = 16'h4E98;
  localparam logic [15:0] ADDR_EXTERNAL_RANGE_SELECT = 16'h4EA2;
  localparam logic [15:0] ADDR_SAMPLE_CLOCK_SOURCE = 16'h4EE8;

  // Encodings of the source and range fields.
  localparam logic [31:0] DIRECT_EXTERNAL_CLOCK_MODE = 32'h0000_0008;
  localparam logic [31:0] SLOW_CLOCK_RANGE = 32'h0000_0040;
  localparam logic [31:0] FAST_CLOCK_RANGE = 32'h0000_0080;

  // Field position of the one-bit controls.
  localparam int unsigned ENABLE_BIT = 0;

  // Reset values.
  localparam logic [31:0] SOURCE_RESET = 32'h0000_0001;
  localparam logic [31:0] RANGE_RESET = SLOW_CLOCK_RANGE;
  localparam logic TERM_RESET = 1'b0;
  localparam logic CLKOUT_RESET = 1'b0;

  // Timing: the core clock rate and the gap after which the link clock
  // counts as absent. A longest time, so the count rounds down.
  localparam int unsigned CORE_CLK_PERIOD_NS = 40;
  localparam int unsigned CLOCK_GAP_NS = 1000;
  localparam int unsigned GAP_CYCLES_RAW = CLOCK_GAP_NS / CORE_CLK_PERIOD_NS;
  localparam int unsigned GAP_CYCLES = (GAP_CYCLES_RAW < 1) ? 1 :
                                       GAP_CYCLES_RAW;
  localparam int unsigned GAP_CNT_W = 8;
  localparam logic [GAP_CNT_W-1:0] GAP_LIMIT = GAP_CNT_W'(GAP_CYCLES);

  typedef struct packed {
    logic [31:0] source;
    logic [31:0] range_sel;
    logic term;
    logic clkout;
  } esc_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } esc_req_t;

  typedef enum logic {
    ESC_STOPPED,
    ESC_RUNNING
  } esc_run_t;

endpackage

// ===== logic/esc_edge_mon.sv
// Link-clock side: toggles a flag on every rising edge of the external clock.
`timescale 1ns/1ps
module esc_edge_mon (
  input wire logic ext_clk,
  input wire logic rst,
  output logic edge_toggle
);

  logic toggle_q;
  logic toggle_d;

  // Any rate down to a stopped clock is fine: nothing here waits for edges.
  always_comb begin
    toggle_d = ~toggle_q;
  end

  always_ff @(posedge ext_clk or posedge rst) begin
    if (rst) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= toggle_d;
    end
  end

  assign edge_toggle = toggle_q;

endmodule

// ===== testbench/esc_checker_assertions.sv
// Port checker for the external sample clock select block.
`timescale 1ns/1ps
module esc_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ext_clk,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic run_start,
  input wire logic run_stop,
  input wire logic running,
  input wire logic conv_clk_ext_sel,
  input wire logic term_50_en,
  input wire logic clk_out_oe,
  input wire logic range_fast,
  input wire logic ext_clk_present,
  input wire logic ext_clk_lost
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  src_write_a: assert property (
    reg_wr && ce && !running &&
    reg_wdata == esc_pkg::DIRECT_EXTERNAL_CLOCK_MODE &&
    reg_addr == esc_pkg::ADDR_SAMPLE_CLOCK_SOURCE |=> ##1 conv_clk_ext_sel)
    else $error("direct mode write not applied");
  term_gate_a: assert property (term_50_en |-> conv_clk_ext_sel)
    else $error("load on without external input");
  clkout_gate_a: assert property (!(clk_out_oe && conv_clk_ext_sel))
    else $error("clock output driven in external mode");
  range_gate_a: assert property (range_fast |-> conv_clk_ext_sel)
    else $error("fast range outside external mode");
  start_run_a: assert property (
    ce && run_start && !run_stop |=> running)
    else $error("start not taken");
  stop_run_a: assert property (ce && run_stop |=> !running)
    else $error("stop not taken");
  lock_write_a: assert property (
    ce && reg_wr && running |=> ##1 $stable(conv_clk_ext_sel))
    else $error("setting changed while running");
  slow_loss_a: assert property (
    $rose(ext_clk_lost) |-> range_fast && $past(running))
    else $error("clock loss flagged outside fast range");
endmodule

// ===== testbench/esc_clk_gen.sv
// Model of the external clock generator on the clock connector.
`timescale 1ns/1ps
module esc_clk_gen (
  input wire logic en,
  output logic clk_out
);
  // 64 ns period stays under every board limit; it parks low when off.
  initial begin
    clk_out = 1'b0;
    #7;
    forever begin
      #32;
      clk_out = en ? ~clk_out : 1'b0;
    end
  end
endmodule

// ===== testbench/esc_top_bench.sv
// Self-checking bench for the external sample clock select block.
`timescale 1ns/1ps
module esc_top_bench;
  logic core_clk, rst, ce, ext_clk, reg_wr, reg_rd, run_start, run_stop;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_rvalid, running, conv_clk_ext_sel, term_50_en, clk_out_oe;
  logic range_fast, ext_clk_present, ext_clk_lost, gen_en;
  int num_errors = 0;
  int num_checks = 0;
  esc_top esc_top_i (.*);
  esc_clk_gen esc_clk_gen_i (.en(gen_en), .clk_out(ext_clk));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(32'(reg_rvalid), 32'h1);
    chk(reg_rdata, exp);
  endtask
  task automatic go(logic s);
    @(posedge core_clk);
    run_start <= s;
    run_stop <= !s;
    @(posedge core_clk);
    run_start <= 1'b0;
    run_stop <= 1'b0;
    #1;
    chk(32'(running), 32'(s));
  endtask
  task automatic t_regs();
    chk(32'(conv_clk_ext_sel), 32'h0);
    rd(esc_pkg::ADDR_SAMPLE_CLOCK_SOURCE, 32'h1);
    rd(esc_pkg::ADDR_EXTERNAL_RANGE_SELECT, 32'h40);
    rd(esc_pkg::ADDR_CLOCK_INPUT_TERMINATION, 32'h0);
    rd(16'h0000, 32'h0);
  endtask
  task automatic t_ext();
    gen_en = 1'b1;
    wr(esc_pkg::ADDR_SAMPLE_CLOCK_SOURCE, 32'h8);
    wr(esc_pkg::ADDR_EXTERNAL_RANGE_SELECT, 32'h80);
    wr(esc_pkg::ADDR_CLOCK_INPUT_TERMINATION, 32'h1);
    wr(esc_pkg::ADDR_CLOCK_OUTPUT_ENABLE, 32'h1);
    cyc(2);
    chk(32'(conv_clk_ext_sel), 32'h1);
    chk(32'(term_50_en), 32'h1);
    chk(32'(range_fast), 32'h1);
    chk(32'(clk_out_oe), 32'h0);
    chk(32'(ext_clk_present), 32'h1);
  endtask
  task automatic t_lock();
    go(1'b1);
    wr(esc_pkg::ADDR_SAMPLE_CLOCK_SOURCE, 32'h1);
    rd(esc_pkg::ADDR_SAMPLE_CLOCK_SOURCE, 32'h8);
    gen_en = 1'b0;
    cyc(40);
    chk(32'(ext_clk_lost), 32'h1);
    go(1'b0);
  endtask
  task automatic t_slow();
    wr(esc_pkg::ADDR_EXTERNAL_RANGE_SELECT, 32'h40);
    gen_en = 1'b1;
    cyc(10);
    go(1'b1);
    gen_en = 1'b0;
    cyc(40);
    chk(32'(ext_clk_lost), 32'h0);
    chk(32'(ext_clk_present), 32'h0);
    gen_en = 1'b1;
    cyc(10);
    chk(32'(ext_clk_present), 32'h1);
    go(1'b0);
  endtask
  task automatic t_int();
    wr(esc_pkg::ADDR_SAMPLE_CLOCK_SOURCE, 32'h1);
    cyc(2);
    chk(32'(conv_clk_ext_sel), 32'h0);
    chk(32'(term_50_en), 32'h0);
    chk(32'(clk_out_oe), 32'h1);
    rd(esc_pkg::ADDR_CLOCK_OUTPUT_ENABLE, 32'h1);
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 32'h0;
    run_start = 1'b0;
    run_stop = 1'b0;
    gen_en = 1'b0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_ext();
    t_lock();
    t_slow();
    t_int();
    wrap_up();
  end
  // The whole run needs about 6 us; a hang is cut off well beyond that.
  initial begin
    #50us;
    num_errors++;
    wrap_up();
  end
endmodule
bind esc_top esc_checker esc_checker_i (.*);
